// [hcb_map.vh]
// hcb_map.vh: command codes, field positions, reset values and timing for the buffer ports
// assumes: included by the buffer port logic only, not by its memory; definitions only
`ifndef HCB_MAP_VH
`define HCB_MAP_VH

// command codes, read and write
`define HCB_CMD_SIZE_RD 8'h30
`define HCB_CMD_SIZE_WR 8'hB0
`define HCB_CMD_DAL_RD 8'h32
`define HCB_CMD_DAL_WR 8'hB2
`define HCB_CMD_ISOA_RD 8'h40
`define HCB_CMD_ISOA_WR 8'hC0
`define HCB_CMD_ISOB_RD 8'h42
`define HCB_CMD_ISOB_WR 8'hC2
`define HCB_CMD_DAD_RD 8'h45
`define HCB_CMD_DAD_WR 8'hC5
`define HCB_CMD_TGL_RD 8'h47
`define HCB_CMD_TGL_WR 8'hC7

// direct address length fields (32-bit register, moved as two words)
`define HCB_DAL_CNT_HI 31
`define HCB_DAL_CNT_LO 16
`define HCB_DAL_ADDR_HI 14
`define HCB_DAL_ADDR_LO 0
`define HCB_DAL_ADDR_W 15

// toggle interval field
`define HCB_TGL_HI 3
`define HCB_TGL_W 4

// reset values
`define HCB_SIZE_RST 16'h0000
`define HCB_DAL_RST 32'h0000_0000
`define HCB_WORD_RST 16'h0000
`define HCB_TGL_RST 4'h0
`define HCB_FIXED_START 16'h0000

// bytes per data word
`define HCB_WORD_BYTES 16'h0002

// timing: one toggle step is 1 ms, clock in kHz
`define HCB_TOGGLE_STEP_MS 1
`define HCB_CLK_KHZ 25000

`endif

// [hcb_buffer_mem.v]
// hcb_buffer_mem.v: single-port word memory holding the host controller buffers
// assumes: one clock; read data appear one edge after the read enable, from a register
`timescale 1ns/1ps
module hcb_buffer_mem #(
    parameter ADDR_W = 11,
    parameter DATA_W = 16
) (
    input wire clk, // system clock
    input wire we, // write enable
    input wire re, // read enable
    input wire [ADDR_W-1:0] addr, // word address
    input wire [DATA_W-1:0] wdata, // write data
    output reg [DATA_W-1:0] rdata // registered read data
);
    reg [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

    always @(posedge clk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
        if (re) begin
            rdata <= mem[addr];
        end
    end
endmodule // hcb_buffer_mem

// [hcb_buffer_ports.v]
// hcb_buffer_ports.v: command-driven access to the host controller buffers and iso settings
// assumes: the driver logic runs on clk; transfer byte counter and buffer state live outside
`timescale 1ns/1ps
`include "hcb_map.vh"

// Contract
// - length register bits 31..16 hold the byte count of a direct access.
// - length register bits 14..0 hold the start address; bit 15 reserved.
// - direct mode reaches any address of iso, interrupt or acknowledged buffers.
// - direct data port moves 16-bit words at the programmed location.
// - direct data port reaches every buffer; its value resets to zero.
// - length register read with 32h, written with B2h.
// - direct data port read with 45h, written with C5h.
// - one 16-bit iso size in bytes, reset zero, serves both iso buffers.
// - iso size read with 30h, written with B0h.
// - first iso port always starts at address zero, no random access.
// - second iso port always starts at address zero, no random access.
// - first iso port read with 40h, written with C0h; words follow.
// - second iso port read with 42h, written with C2h; words follow.
// - first iso pointer advances on each word access; the code stops advancing it once its end flag is set.
// - first iso pointer reaching transfer count raises end flag and updates state.
// - second iso pointer advances on each word access; the code stops advancing it once its end flag is set.
// - second iso pointer reaching transfer count raises end flag and updates state.
// - iso buffers switch every 0 to 15 ms in 1 ms steps; the code holds the current buffer at interval zero.
// - toggle interval is bits 3..0, reset zero; bits 15..4 reserved.
// - toggle interval read with 47h, written with C7h.
module hcb_buffer_ports #(
    parameter ADDR_W = 11,
    parameter MS_CYCLES = `HCB_TOGGLE_STEP_MS * `HCB_CLK_KHZ
) (
    input wire clk, // system clock, 25 MHz
    input wire rstn, // synchronous reset, active low
    input wire cmd_stb, // command code strobe
    input wire [7:0] cmd_code, // command code
    input wire wr_stb, // data word write strobe
    input wire [15:0] wr_word, // data word written
    input wire rd_stb, // data word read strobe
    output wire [15:0] rd_word, // data word read, valid with rd_valid
    output reg rd_valid, // read data valid pulse
    input wire [15:0] xfer_total, // transfer byte counter value
    output reg eot_pulse, // sets the all end of transfer flag
    output reg iso_a_done, // buffer state update, first iso buffer finished
    output reg iso_b_done, // buffer state update, second iso buffer finished
    output reg iso_active_b, // iso buffer in use by the link side
    output reg cmd_reject // pulse on an unknown command code
);
    localparam M_NONE = 3'd0;
    localparam M_SIZE = 3'd1;
    localparam M_DAL = 3'd2;
    localparam M_ISOA = 3'd3;
    localparam M_ISOB = 3'd4;
    localparam M_DAD = 3'd5;
    localparam M_TGL = 3'd6;

    // decode: {known, write, mode}
    function [4:0] cmd_decode;
        input [7:0] code;
        begin
            case (code)
                `HCB_CMD_SIZE_RD: cmd_decode = {2'b10, M_SIZE};
                `HCB_CMD_SIZE_WR: cmd_decode = {2'b11, M_SIZE};
                `HCB_CMD_DAL_RD: cmd_decode = {2'b10, M_DAL};
                `HCB_CMD_DAL_WR: cmd_decode = {2'b11, M_DAL};
                `HCB_CMD_ISOA_RD: cmd_decode = {2'b10, M_ISOA};
                `HCB_CMD_ISOA_WR: cmd_decode = {2'b11, M_ISOA};
                `HCB_CMD_ISOB_RD: cmd_decode = {2'b10, M_ISOB};
                `HCB_CMD_ISOB_WR: cmd_decode = {2'b11, M_ISOB};
                `HCB_CMD_DAD_RD: cmd_decode = {2'b10, M_DAD};
                `HCB_CMD_DAD_WR: cmd_decode = {2'b11, M_DAD};
                `HCB_CMD_TGL_RD: cmd_decode = {2'b10, M_TGL};
                `HCB_CMD_TGL_WR: cmd_decode = {2'b11, M_TGL};
                default: cmd_decode = {2'b00, M_NONE};
            endcase
        end
    endfunction

    reg [2:0] mode_r;
    reg dir_wr_r;
    reg half_r;
    reg [15:0] iso_size_r;
    reg [31:0] dal_r;
    reg [3:0] tgl_r;
    reg [15:0] ptr_a_r;
    reg [15:0] ptr_b_r;
    reg end_a_r;
    reg end_b_r;
    reg [`HCB_DAL_ADDR_W-1:0] dad_ptr_r;
    reg [15:0] dad_left_r;
    reg [15:0] hold_r;
    reg from_mem_r;
    reg [31:0] ms_cnt_r;
    reg [3:0] ms_elapsed_r;

    wire [4:0] dec = cmd_decode(cmd_code);
    wire access = (wr_stb & dir_wr_r) | (rd_stb & ~dir_wr_r);
    wire [15:0] ptr_a_nxt = ptr_a_r + `HCB_WORD_BYTES;
    wire [15:0] ptr_b_nxt = ptr_b_r + `HCB_WORD_BYTES;
    // second iso buffer sits right after the first, both of iso_size bytes
    wire [15:0] iso_b_byte = iso_size_r + ptr_b_r;
    wire [15:0] dad_byte = {1'b0, dad_ptr_r};

    reg mem_we;
    reg mem_re;
    reg [15:0] mem_byte;
    wire [15:0] mem_q;

    always @* begin
        mem_we = 1'b0;
        mem_re = 1'b0;
        mem_byte = 16'h0000;
        if (access && !cmd_stb) begin
            case (mode_r)
                M_ISOA: begin
                    mem_byte = ptr_a_r;
                    mem_we = dir_wr_r & ~end_a_r;
                    mem_re = ~dir_wr_r & ~end_a_r;
                end
                M_ISOB: begin
                    mem_byte = iso_b_byte;
                    mem_we = dir_wr_r & ~end_b_r;
                    mem_re = ~dir_wr_r & ~end_b_r;
                end
                M_DAD: begin
                    mem_byte = dad_byte;
                    mem_we = dir_wr_r & (dad_left_r != 16'h0000);
                    mem_re = ~dir_wr_r & (dad_left_r != 16'h0000);
                end
                default: begin
                    mem_we = 1'b0;
                end
            endcase
        end
    end

    hcb_buffer_mem #(
        .ADDR_W(ADDR_W),
        .DATA_W(16)
    ) u_mem (
        .clk(clk),
        .we(mem_we),
        .re(mem_re),
        .addr(mem_byte[ADDR_W:1]),
        .wdata(wr_word),
        .rdata(mem_q)
    );

    // data port shows the held word unless the last access, read or write, hit a buffer port with words left
    assign rd_word = from_mem_r ? mem_q : hold_r;

    always @(posedge clk) begin
        if (!rstn) begin
            mode_r <= M_NONE;
            dir_wr_r <= 1'b0;
            half_r <= 1'b0;
            iso_size_r <= `HCB_SIZE_RST;
            dal_r <= `HCB_DAL_RST;
            tgl_r <= `HCB_TGL_RST;
            ptr_a_r <= `HCB_FIXED_START;
            ptr_b_r <= `HCB_FIXED_START;
            end_a_r <= 1'b0;
            end_b_r <= 1'b0;
            dad_ptr_r <= 15'h0000;
            dad_left_r <= 16'h0000;
            hold_r <= `HCB_WORD_RST;
            from_mem_r <= 1'b0;
            rd_valid <= 1'b0;
            eot_pulse <= 1'b0;
            iso_a_done <= 1'b0;
            iso_b_done <= 1'b0;
            cmd_reject <= 1'b0;
        end else begin
            rd_valid <= 1'b0;
            eot_pulse <= 1'b0;
            iso_a_done <= 1'b0;
            iso_b_done <= 1'b0;
            cmd_reject <= 1'b0;
            if (cmd_stb) begin
                if (dec[4]) begin
                    mode_r <= dec[2:0];
                    dir_wr_r <= dec[3];
                    half_r <= 1'b0;
                    // first iso port restarts at zero
                    if (dec[2:0] == M_ISOA) begin
                        ptr_a_r <= `HCB_FIXED_START;
                        end_a_r <= (xfer_total == 16'h0000);
                    end
                    // second iso port restarts at zero
                    if (dec[2:0] == M_ISOB) begin
                        ptr_b_r <= `HCB_FIXED_START;
                        end_b_r <= (xfer_total == 16'h0000);
                    end
                    // direct port restarts at programmed start
                    if (dec[2:0] == M_DAD) begin
                        dad_ptr_r <= dal_r[`HCB_DAL_ADDR_HI:`HCB_DAL_ADDR_LO];
                        dad_left_r <= dal_r[`HCB_DAL_CNT_HI:`HCB_DAL_CNT_LO];
                    end
                end else begin
                    mode_r <= M_NONE;
                    cmd_reject <= 1'b1;
                end
            end else if (access) begin
                rd_valid <= ~dir_wr_r;
                from_mem_r <= 1'b0;
                case (mode_r)
                    M_SIZE: begin
                        if (dir_wr_r) begin
                            iso_size_r <= wr_word;
                        end else begin
                            hold_r <= iso_size_r;
                        end
                    end
                    // length register, low word then high word
                    M_DAL: begin
                        half_r <= ~half_r;
                        if (dir_wr_r && !half_r) begin
                            dal_r[`HCB_DAL_ADDR_HI:`HCB_DAL_ADDR_LO] <=
                                wr_word[`HCB_DAL_ADDR_W-1:0];
                        end else if (dir_wr_r) begin
                            dal_r[`HCB_DAL_CNT_HI:`HCB_DAL_CNT_LO] <= wr_word;
                        end else if (!half_r) begin
                            hold_r <= {1'b0, dal_r[`HCB_DAL_ADDR_HI:`HCB_DAL_ADDR_LO]};
                        end else begin
                            hold_r <= dal_r[`HCB_DAL_CNT_HI:`HCB_DAL_CNT_LO];
                        end
                    end
                    M_ISOA: begin
                        from_mem_r <= ~end_a_r;
                        if (!end_a_r) begin
                            ptr_a_r <= ptr_a_nxt;
                            if (ptr_a_nxt >= xfer_total) begin
                                end_a_r <= 1'b1;
                                eot_pulse <= 1'b1;
                                iso_a_done <= 1'b1;
                            end
                        end else begin
                            hold_r <= `HCB_WORD_RST;
                        end
                    end
                    M_ISOB: begin
                        from_mem_r <= ~end_b_r;
                        if (!end_b_r) begin
                            ptr_b_r <= ptr_b_nxt;
                            if (ptr_b_nxt >= xfer_total) begin
                                end_b_r <= 1'b1;
                                eot_pulse <= 1'b1;
                                iso_b_done <= 1'b1;
                            end
                        end else begin
                            hold_r <= `HCB_WORD_RST;
                        end
                    end
                    M_DAD: begin
                        from_mem_r <= (dad_left_r != 16'h0000);
                        if (dad_left_r != 16'h0000) begin
                            dad_ptr_r <= dad_ptr_r + 15'h0002;
                            if (dad_left_r > `HCB_WORD_BYTES) begin
                                dad_left_r <= dad_left_r - `HCB_WORD_BYTES;
                            end else begin
                                dad_left_r <= 16'h0000;
                            end
                        end else begin
                            hold_r <= `HCB_WORD_RST;
                        end
                    end
                    M_TGL: begin
                        if (dir_wr_r) begin
                            tgl_r <= wr_word[`HCB_TGL_HI:0];
                        end else begin
                            hold_r <= {12'h000, tgl_r};
                        end
                    end
                    default: begin
                        hold_r <= `HCB_WORD_RST;
                    end
                endcase
            end
        end
    end

    // millisecond tick and iso buffer switching
    wire ms_tick = (ms_cnt_r == MS_CYCLES - 1);

    always @(posedge clk) begin
        if (!rstn) begin
            ms_cnt_r <= 32'h0000_0000;
            ms_elapsed_r <= 4'h0;
            iso_active_b <= 1'b0;
        end else begin
            if (ms_tick) begin
                ms_cnt_r <= 32'h0000_0000;
            end else begin
                ms_cnt_r <= ms_cnt_r + 32'h0000_0001;
            end
            // interval zero holds the current buffer
            if (tgl_r == `HCB_TGL_RST) begin
                ms_elapsed_r <= 4'h0;
            end else if (ms_tick) begin
                if (ms_elapsed_r >= tgl_r - 4'h1) begin
                    ms_elapsed_r <= 4'h0;
                    iso_active_b <= ~iso_active_b;
                end else begin
                    ms_elapsed_r <= ms_elapsed_r + 4'h1;
                end
            end
        end
    end
endmodule // hcb_buffer_ports

// [hcb_ports_sva.sv]
// hcb_ports_sva.sv: timing checks on the buffer port pins
// assumes: bound to hcb_buffer_ports; one clock, synchronous active-low reset
`timescale 1ns/1ps
module hcb_ports_sva #(
    parameter MS_CYCLES = 10
) (
    input wire clk, // system clock
    input wire rstn, // synchronous reset, active low
    input wire cmd_stb, // command strobe
    input wire [7:0] cmd_code, // command code
    input wire wr_stb, // write strobe
    input wire rd_stb, // read strobe
    input wire [15:0] rd_word, // read data
    input wire rd_valid, // read data valid
    input wire eot_pulse, // end of transfer pulse
    input wire iso_a_done, // first iso buffer finished
    input wire iso_b_done, // second iso buffer finished
    input wire iso_active_b, // iso buffer in use
    input wire cmd_reject // unknown code pulse
);
    wire known_code;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    assign known_code = cmd_code inside {8'h30, 8'hB0, 8'h32, 8'hB2, 8'h40, 8'hC0,
        8'h42, 8'hC2, 8'h45, 8'hC5, 8'h47, 8'hC7};

    a_reset_quiet: assert property ($rose(rstn) |-> !rd_valid && !eot_pulse &&
        !iso_active_b && !cmd_reject && rd_word == 16'h0000)
        else $error("outputs not idle after reset");
    a_read_latency: assert property (rd_valid |-> $past(rd_stb))
        else $error("read valid without a read strobe one cycle before");
    a_known_code: assert property (cmd_stb && known_code |=> !cmd_reject)
        else $error("known command refused");
    a_unknown_code: assert property (cmd_stb && !known_code |=> cmd_reject)
        else $error("unknown command not refused");
    a_done_a_flag: assert property (iso_a_done |-> eot_pulse && !iso_b_done)
        else $error("first iso done without end flag");
    a_done_b_flag: assert property (iso_b_done |-> eot_pulse)
        else $error("second iso done without end flag");
    a_done_cause: assert property (iso_a_done || iso_b_done |->
        $past(rd_stb) || $past(wr_stb) || $past(cmd_stb))
        else $error("iso done without an access");
    a_toggle_step: assert property ($changed(iso_active_b) |=>
        $stable(iso_active_b) [*8])
        else $error("iso buffer switched faster than one step");
endmodule // hcb_ports_sva

// [hcb_ctr_model.sv]
// hcb_ctr_model.sv: driver-side transfer byte counter feeding the port logic
// assumes: the bench loads it once, before the first iso port command
`timescale 1ns/1ps
module hcb_ctr_model (
    input wire clk, // system clock
    input wire rstn, // synchronous reset, active low
    input wire ld, // load strobe
    input wire [15:0] ld_val, // byte count to load
    output wire [15:0] xfer_total // transfer byte counter value
);
    reg [15:0] xfer_total_r;

    assign xfer_total = xfer_total_r;
    always @(posedge clk) begin
        if (!rstn) begin
            xfer_total_r <= 16'h0000;
        end else if (ld) begin
            xfer_total_r <= ld_val;
        end
    end
endmodule // hcb_ctr_model

// [tb_hc_buffer_access_ports.sv]
// tb_hc_buffer_access_ports.sv: command and word sequences against the buffer ports
// assumes: inputs change at the falling edge; toggle step shortened to 10 cycles
`timescale 1ns/1ps
module tb_hc_buffer_access_ports;
    localparam MS_CYCLES = 10;
    reg clk, rstn, cmd_stb, wr_stb, rd_stb, ld;
    reg [7:0] cmd_code;
    reg [15:0] wr_word, ld_val, ev, n;
    wire [15:0] rd_word, xfer_total;
    wire rd_valid, eot_pulse, iso_a_done, iso_b_done, iso_active_b, cmd_reject;
    integer failures = 0, checks = 0, cyc = 0;

    hcb_buffer_ports #(.MS_CYCLES(MS_CYCLES)) hcb_buffer_ports_inst (.clk(clk), .rstn(rstn),
        .cmd_stb(cmd_stb), .cmd_code(cmd_code), .wr_stb(wr_stb), .wr_word(wr_word),
        .rd_stb(rd_stb), .rd_word(rd_word), .rd_valid(rd_valid), .xfer_total(xfer_total),
        .eot_pulse(eot_pulse), .iso_a_done(iso_a_done), .iso_b_done(iso_b_done),
        .iso_active_b(iso_active_b), .cmd_reject(cmd_reject));
    hcb_ctr_model hcb_ctr_model_inst (.clk(clk), .rstn(rstn), .ld(ld), .ld_val(ld_val),
        .xfer_total(xfer_total));

    task summarize;
        begin
            $display("checks=%0d failures=%0d", checks, failures);
            if (failures == 0 && checks > 0)
                $display("DONE - PASS");
            else
                $display("DONE - FAIL");
            $finish;
        end
    endtask
    task chk(input logic [15:0] got, input logic [15:0] exp);
        begin
            checks = checks + 1;
            if (got !== exp) begin
                failures = failures + 1;
                $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    // all bus tasks enter and leave at a falling edge
    task cmd(input logic [7:0] c);
        begin
            cmd_stb = 1'b1;
            cmd_code = c;
            @(negedge clk);
            cmd_stb = 1'b0;
            ev = {15'h0000, cmd_reject};
            @(negedge clk);
        end
    endtask
    task wr(input logic [15:0] w);
        begin
            wr_stb = 1'b1;
            wr_word = w;
            @(negedge clk);
            wr_stb = 1'b0;
            ev = {13'h0000, eot_pulse, iso_a_done, iso_b_done};
            @(negedge clk);
        end
    endtask
    task rd(input logic [15:0] exp);
        begin
            rd_stb = 1'b1;
            @(negedge clk);
            rd_stb = 1'b0;
            chk({15'h0000, rd_valid}, 16'h0001);
            chk(rd_word, exp);
            ev = {13'h0000, eot_pulse, iso_a_done, iso_b_done};
            @(negedge clk);
        end
    endtask
    task dal(input logic [15:0] a, input logic [15:0] c);
        begin
            cmd(8'hB2);
            wr(a);
            wr(c);
        end
    endtask
    task flip;
        reg v;
        begin
            n = 16'h0000;
            v = iso_active_b;
            while (iso_active_b === v && n < 16'h0064) begin
                @(negedge clk);
                n = n + 16'h0001;
            end
        end
    endtask

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 5000) begin
            failures = failures + 1;
            summarize;
        end
    end

    initial begin
        rstn = 1'b0;
        {cmd_stb, wr_stb, rd_stb, ld} = 4'h0;
        cmd_code = 8'h00;
        wr_word = 16'h0000;
        ld_val = 16'h0000;
        repeat (8) @(posedge clk);
        @(negedge clk);
        rstn = 1'b1;
        cmd(8'h30);
        rd(16'h0000);
        cmd(8'h47);
        rd(16'h0000);
        cmd(8'h32);
        rd(16'h0000);
        rd(16'h0000);
        dal(16'hFFFE, 16'h1234);
        cmd(8'h32);
        rd(16'h7FFE);
        rd(16'h1234);
        cmd(8'hB0);
        wr(16'h0010);
        cmd(8'h30);
        rd(16'h0010);
        ld_val = 16'h0004;
        ld = 1'b1;
        @(negedge clk);
        ld = 1'b0;
        cmd(8'hC0);
        wr(16'hA1A1);
        chk(ev, 16'h0000);
        wr(16'hB2B2);
        chk(ev, 16'h0006);
        cmd(8'h40);
        rd(16'hA1A1);
        rd(16'hB2B2);
        chk(ev, 16'h0006);
        rd(16'h0000);
        cmd(8'hC2);
        wr(16'hC3C3);
        wr(16'hD4D4);
        chk(ev, 16'h0005);
        cmd(8'h42);
        rd(16'hC3C3);
        rd(16'hD4D4);
        // refused code must drop the size write mode set just before it
        cmd(8'hB0);
        cmd(8'h99);
        chk(ev, 16'h0001);
        wr(16'hDEAD);
        cmd(8'h30);
        rd(16'h0010);
        cmd(8'h40);
        rd(16'hA1A1);
        dal(16'h0010, 16'h0004);
        cmd(8'h45);
        rd(16'hC3C3);
        rd(16'hD4D4);
        rd(16'h0000);
        dal(16'h0022, 16'h0002);
        cmd(8'hC5);
        wr(16'h5E5E);
        dal(16'h0022, 16'h0002);
        cmd(8'h45);
        rd(16'h5E5E);
        cmd(8'hC7);
        wr(16'hFFF1);
        cmd(8'h47);
        rd(16'h0001);
        flip;
        flip;
        chk(n, 16'h000A);
        cmd(8'hC7);
        wr(16'h0000);
        flip;
        chk(n, 16'h0064);
        // mid-run reset clears every register again
        rstn = 1'b0;
        repeat (2) @(negedge clk);
        rstn = 1'b1;
        cmd(8'h30);
        rd(16'h0000);
        cmd(8'h47);
        rd(16'h0000);
        cmd(8'h32);
        rd(16'h0000);
        rd(16'h0000);
        cmd(8'h45);
        rd(16'h0000);
        summarize;
    end
endmodule // tb_hc_buffer_access_ports

bind hcb_buffer_ports hcb_ports_sva #(.MS_CYCLES(MS_CYCLES)) hcb_ports_sva_inst (.clk(clk),
    .rstn(rstn), .cmd_stb(cmd_stb), .cmd_code(cmd_code), .wr_stb(wr_stb), .rd_stb(rd_stb),
    .rd_word(rd_word), .rd_valid(rd_valid), .eot_pulse(eot_pulse), .iso_a_done(iso_a_done),
    .iso_b_done(iso_b_done), .iso_active_b(iso_active_b), .cmd_reject(cmd_reject));
